// [rtl/bfiu_regs.vh]
`ifndef BFIU_REGS_VH
`define BFIU_REGS_VH

////////////////////////////////////////////////////////////////////////////
// operation codes presented on op_code
`define BFIU_OP_PUSH                  5'h00
`define BFIU_OP_POP                   5'h01
`define BFIU_OP_IO_BIT_SET            5'h02
`define BFIU_OP_IO_BIT_CLEAR          5'h03
`define BFIU_OP_SHIFT_LEFT_LOGICAL    5'h04
`define BFIU_OP_SHIFT_RIGHT_LOGICAL   5'h05
`define BFIU_OP_ROTATE_LEFT_CARRY     5'h06
`define BFIU_OP_ROTATE_RIGHT_CARRY    5'h07
`define BFIU_OP_SHIFT_RIGHT_ARITH     5'h08
`define BFIU_OP_NIBBLE_SWAP           5'h09
`define BFIU_OP_FLAG_SET_GENERIC      5'h0a
`define BFIU_OP_FLAG_CLEAR_GENERIC    5'h0b
`define BFIU_OP_BIT_TO_TRANSFER_FLAG  5'h0c
`define BFIU_OP_TRANSFER_FLAG_TO_BIT  5'h0d
`define BFIU_OP_CARRY_FORCE_ONE       5'h0e
`define BFIU_OP_CARRY_FORCE_ZERO      5'h0f
`define BFIU_OP_NEGATIVE_FORCE_ONE    5'h10
`define BFIU_OP_NEGATIVE_FORCE_ZERO   5'h11
`define BFIU_OP_ZERO_FLAG_FORCE_ONE   5'h12
`define BFIU_OP_ZERO_FLAG_FORCE_ZERO  5'h13
`define BFIU_OP_GLOBAL_IRQ_ENABLE     5'h14
`define BFIU_OP_GLOBAL_IRQ_DISABLE    5'h15
`define BFIU_OP_SIGN_FLAG_FORCE_ONE   5'h16
`define BFIU_OP_SIGN_FLAG_FORCE_ZERO  5'h17
`define BFIU_OP_OVERFLOW_FORCE_ONE    5'h18
`define BFIU_OP_OVERFLOW_FORCE_ZERO   5'h19
`define BFIU_OP_TRANSFER_FORCE_ONE    5'h1a
`define BFIU_OP_TRANSFER_FORCE_ZERO   5'h1b

////////////////////////////////////////////////////////////////////////////
// status register field positions
`define BFIU_FLAG_C                   3'h0
`define BFIU_FLAG_Z                   3'h1
`define BFIU_FLAG_N                   3'h2
`define BFIU_FLAG_V                   3'h3
`define BFIU_FLAG_S                   3'h4
`define BFIU_FLAG_H                   3'h5
`define BFIU_FLAG_T                   3'h6
`define BFIU_FLAG_I                   3'h7

////////////////////////////////////////////////////////////////////////////
// reset values and stack pointer step
`define BFIU_STATUS_RESET             8'h00
`define BFIU_SP_RESET                 16'h00ff
`define BFIU_SP_STEP                  16'h0001

`endif

// [rtl/bfiu_unit.v]
// Summary of operation
// - push writes source to stack, two cycles
// - pop loads destination from stack, two cycles
// - io set forces chosen bit to one
// - io clear forces chosen bit to zero
// - logical left shift, zero into bit 0
// - logical right shift, zero into bit 7
// - rotate left: carry in bit 0, bit7 out
// - rotate right: carry in bit 7, bit0 out
// - arithmetic right shift keeps sign bit
// - swap upper and lower nibbles at once
// - generic flag set/clear by bit index
// - copy chosen source bit into transfer flag
// - copy transfer flag into chosen destination bit
// - carry set/clear, no other flag touched
// - negative set/clear, others untouched
// - zero flag set/clear, others untouched
// - interrupt enable set and clear
// - sign flag set/clear, others untouched
// - overflow set/clear, others untouched
// - transfer flag set, others untouched
// - transfer flag clear, others untouched
`include "bfiu_regs.vh"

module bfiu_unit (
    // clock and reset
    input  wire        clk_sys,
    input  wire        srst,
    // operation request
    input  wire        op_valid,
    input  wire [4:0]  op_code,
    input  wire [2:0]  op_bit,
    input  wire [4:0]  rd_addr,
    input  wire [7:0]  rd_data,
    input  wire [7:0]  source_reg,
    input  wire [4:0]  io_addr,
    // operation status
    output reg         busy_r,
    output reg         done_r,
    output reg         illegal_r,
    // register file write
    output reg         rf_we_r,
    output reg  [4:0]  rf_waddr_r,
    output reg  [7:0]  rf_wdata_r,
    // stack memory
    output reg         stk_we_r,
    output reg         stk_re_r,
    output reg  [15:0] stk_addr_r,
    output reg  [7:0]  stk_wdata_r,
    input  wire [7:0]  stk_rdata,
    // io space
    output reg         io_re_r,
    output reg         io_we_r,
    output reg  [4:0]  io_addr_r,
    output reg  [7:0]  io_wdata_r,
    input  wire [7:0]  io_rdata,
    // core state
    output reg  [7:0]  status_register_r,
    output reg  [15:0] sp_r
);

////////////////////////////////////////////////////////////////////////////
// sequencer states

localparam [2:0] S_IDLE  = 3'h0;
localparam [2:0] S_PUSH  = 3'h1;
localparam [2:0] S_POP   = 3'h2;
localparam [2:0] S_IO_RD = 3'h3;
localparam [2:0] S_IO_WR = 3'h4;

reg  [2:0] state_r;
reg  [2:0] bit_r;
reg        io_set_r;

////////////////////////////////////////////////////////////////////////////
// one-hot bit selects

wire [7:0] sel_now;
wire [7:0] sel_held;

genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sel
        assign sel_now[gi]  = (op_bit == gi);
        assign sel_held[gi] = (bit_r == gi);
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// shift, rotate, swap and bit-load datapath

reg  [7:0] alu_res;
reg        alu_c;
reg        alu_wc;
reg        alu_hit;

wire       c_old = status_register_r[`BFIU_FLAG_C];
wire       t_old = status_register_r[`BFIU_FLAG_T];

always @* begin
    alu_res = rd_data;
    alu_c   = c_old;
    alu_wc  = 1'b0;
    alu_hit = 1'b1;
    case (op_code)
        `BFIU_OP_SHIFT_LEFT_LOGICAL: begin
            alu_res = {rd_data[6:0], 1'b0};
            alu_c   = rd_data[7];
            alu_wc  = 1'b1;
        end
        `BFIU_OP_SHIFT_RIGHT_LOGICAL: begin
            alu_res = {1'b0, rd_data[7:1]};
            alu_c   = rd_data[0];
            alu_wc  = 1'b1;
        end
        `BFIU_OP_ROTATE_LEFT_CARRY: begin
            alu_res = {rd_data[6:0], c_old};
            alu_c   = rd_data[7];
            alu_wc  = 1'b1;
        end
        `BFIU_OP_ROTATE_RIGHT_CARRY: begin
            alu_res = {c_old, rd_data[7:1]};
            alu_c   = rd_data[0];
            alu_wc  = 1'b1;
        end
        `BFIU_OP_SHIFT_RIGHT_ARITH: begin
            alu_res = {rd_data[7], rd_data[7:1]};
            alu_c   = rd_data[0];
            alu_wc  = 1'b1;
        end
        `BFIU_OP_NIBBLE_SWAP: begin
            alu_res = {rd_data[3:0], rd_data[7:4]};
        end
        `BFIU_OP_TRANSFER_FLAG_TO_BIT: begin
            // only the selected bit moves, the rest pass through
            if (t_old) begin
                alu_res = rd_data | sel_now;
            end else begin
                alu_res = rd_data & ~sel_now;
            end
        end
        default: begin
            alu_hit = 1'b0;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////
// dedicated single-flag operations

reg        ded_hit;
reg  [2:0] ded_idx;
reg        ded_val;

always @* begin
    ded_hit = 1'b1;
    ded_idx = `BFIU_FLAG_C;
    ded_val = 1'b0;
    case (op_code)
        `BFIU_OP_CARRY_FORCE_ONE: begin
            ded_idx = `BFIU_FLAG_C;
            ded_val = 1'b1;
        end
        `BFIU_OP_CARRY_FORCE_ZERO: begin
            ded_idx = `BFIU_FLAG_C;
            ded_val = 1'b0;
        end
        `BFIU_OP_NEGATIVE_FORCE_ONE: begin
            ded_idx = `BFIU_FLAG_N;
            ded_val = 1'b1;
        end
        `BFIU_OP_NEGATIVE_FORCE_ZERO: begin
            ded_idx = `BFIU_FLAG_N;
            ded_val = 1'b0;
        end
        `BFIU_OP_ZERO_FLAG_FORCE_ONE: begin
            ded_idx = `BFIU_FLAG_Z;
            ded_val = 1'b1;
        end
        `BFIU_OP_ZERO_FLAG_FORCE_ZERO: begin
            ded_idx = `BFIU_FLAG_Z;
            ded_val = 1'b0;
        end
        `BFIU_OP_GLOBAL_IRQ_ENABLE: begin
            ded_idx = `BFIU_FLAG_I;
            ded_val = 1'b1;
        end
        `BFIU_OP_GLOBAL_IRQ_DISABLE: begin
            ded_idx = `BFIU_FLAG_I;
            ded_val = 1'b0;
        end
        `BFIU_OP_SIGN_FLAG_FORCE_ONE: begin
            ded_idx = `BFIU_FLAG_S;
            ded_val = 1'b1;
        end
        `BFIU_OP_SIGN_FLAG_FORCE_ZERO: begin
            ded_idx = `BFIU_FLAG_S;
            ded_val = 1'b0;
        end
        `BFIU_OP_OVERFLOW_FORCE_ONE: begin
            ded_idx = `BFIU_FLAG_V;
            ded_val = 1'b1;
        end
        `BFIU_OP_OVERFLOW_FORCE_ZERO: begin
            ded_idx = `BFIU_FLAG_V;
            ded_val = 1'b0;
        end
        `BFIU_OP_TRANSFER_FORCE_ONE: begin
            ded_idx = `BFIU_FLAG_T;
            ded_val = 1'b1;
        end
        `BFIU_OP_TRANSFER_FORCE_ZERO: begin
            ded_idx = `BFIU_FLAG_T;
            ded_val = 1'b0;
        end
        `BFIU_OP_FLAG_SET_GENERIC: begin
            ded_idx = op_bit;
            ded_val = 1'b1;
        end
        `BFIU_OP_FLAG_CLEAR_GENERIC: begin
            ded_idx = op_bit;
            ded_val = 1'b0;
        end
        `BFIU_OP_BIT_TO_TRANSFER_FLAG: begin
            ded_idx = `BFIU_FLAG_T;
            ded_val = source_reg[op_bit];
        end
        default: begin
            ded_hit = 1'b0;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////
// sequencer

always @(posedge clk_sys) begin
    if (srst) begin
        state_r           <= S_IDLE;
        bit_r             <= 3'h0;
        io_set_r          <= 1'b0;
        busy_r            <= 1'b0;
        done_r            <= 1'b0;
        illegal_r         <= 1'b0;
        rf_we_r           <= 1'b0;
        rf_waddr_r        <= 5'h00;
        rf_wdata_r        <= 8'h00;
        stk_we_r          <= 1'b0;
        stk_re_r          <= 1'b0;
        stk_addr_r        <= 16'h0000;
        stk_wdata_r       <= 8'h00;
        io_re_r           <= 1'b0;
        io_we_r           <= 1'b0;
        io_addr_r         <= 5'h00;
        io_wdata_r        <= 8'h00;
        status_register_r <= `BFIU_STATUS_RESET;
        sp_r              <= `BFIU_SP_RESET;
    end else begin
        // strobes last one cycle unless a state renews them
        done_r    <= 1'b0;
        illegal_r <= 1'b0;
        rf_we_r   <= 1'b0;
        stk_we_r  <= 1'b0;
        stk_re_r  <= 1'b0;
        io_re_r   <= 1'b0;
        io_we_r   <= 1'b0;
        case (state_r)
            S_IDLE: begin
                if (op_valid) begin
                    rf_waddr_r <= rd_addr;
                    bit_r      <= op_bit;
                    if (op_code == `BFIU_OP_PUSH) begin
                        stk_we_r    <= 1'b1;
                        stk_addr_r  <= sp_r;
                        stk_wdata_r <= source_reg;
                        busy_r      <= 1'b1;
                        state_r     <= S_PUSH;
                    end else if (op_code == `BFIU_OP_POP) begin
                        // pre-increment so the read sees the top byte
                        sp_r       <= sp_r + `BFIU_SP_STEP;
                        stk_addr_r <= sp_r + `BFIU_SP_STEP;
                        stk_re_r   <= 1'b1;
                        busy_r     <= 1'b1;
                        state_r    <= S_POP;
                    end else if (op_code == `BFIU_OP_IO_BIT_SET ||
                                 op_code == `BFIU_OP_IO_BIT_CLEAR) begin
                        // read-modify-write keeps the other bits
                        io_re_r   <= 1'b1;
                        io_addr_r <= io_addr;
                        io_set_r  <= (op_code == `BFIU_OP_IO_BIT_SET);
                        busy_r    <= 1'b1;
                        state_r   <= S_IO_RD;
                    end else if (alu_hit) begin
                        rf_we_r    <= 1'b1;
                        rf_wdata_r <= alu_res;
                        if (alu_wc) begin
                            status_register_r[`BFIU_FLAG_C] <= alu_c;
                        end
                        done_r <= 1'b1;
                    end else if (ded_hit) begin
                        status_register_r[ded_idx] <= ded_val;
                        done_r <= 1'b1;
                    end else begin
                        // unknown codes complete with no effect
                        illegal_r <= 1'b1;
                        done_r    <= 1'b1;
                    end
                end
            end
            S_PUSH: begin
                // post-decrement after the write cycle
                sp_r    <= sp_r - `BFIU_SP_STEP;
                done_r  <= 1'b1;
                busy_r  <= 1'b0;
                state_r <= S_IDLE;
            end
            S_POP: begin
                // stack memory answers in the read cycle
                rf_we_r    <= 1'b1;
                rf_wdata_r <= stk_rdata;
                done_r     <= 1'b1;
                busy_r     <= 1'b0;
                state_r    <= S_IDLE;
            end
            S_IO_RD: begin
                io_we_r <= 1'b1;
                if (io_set_r) begin
                    io_wdata_r <= io_rdata | sel_held;
                end else begin
                    io_wdata_r <= io_rdata & ~sel_held;
                end
                state_r <= S_IO_WR;
            end
            S_IO_WR: begin
                done_r  <= 1'b1;
                busy_r  <= 1'b0;
                state_r <= S_IDLE;
            end
            default: begin
                busy_r  <= 1'b0;
                state_r <= S_IDLE;
            end
        endcase
    end
end

endmodule

// [test/bfiu_unit_checker.sv]
module bfiu_checker (
    // clock and reset
    input logic        clk_sys,
    input logic        srst,
    // request
    input logic        op_valid,
    input logic [4:0]  op_code,
    input logic [2:0]  op_bit,
    input logic [7:0]  rd_data,
    input logic [7:0]  source_reg,
    // results
    input logic        busy_r,
    input logic        done_r,
    input logic        rf_we_r,
    input logic [7:0]  rf_wdata_r,
    input logic        stk_we_r,
    input logic        stk_re_r,
    input logic [7:0]  stk_wdata_r,
    input logic [7:0]  stk_rdata,
    input logic        io_re_r,
    input logic        io_we_r,
    input logic [7:0]  io_wdata_r,
    input logic [7:0]  io_rdata,
    input logic [7:0]  status_register_r,
    input logic [15:0] sp_r
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rd_q;
    logic [7:0] sr_q;
    logic [7:0] src_q;
    // operands as they stood at the taking edge
    always_ff @(posedge clk_sys) begin
        rd_q <= rd_data;
        sr_q <= status_register_r;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence take(logic [4:0] c);
        op_valid && !busy_r && op_code == c;
    endsequence
    sequence push_tail;
        stk_we_r && stk_wdata_r == src_q ##1 done_r && !busy_r;
    endsequence
    sequence pop_tail;
        stk_re_r ##1 done_r && rf_we_r && rf_wdata_r == $past(stk_rdata);
    endsequence
    always_ff @(posedge clk_sys) src_q <= source_reg;
    AST_PUSH: assert property (take(5'h00) |=> push_tail)
        else $error("push write or completion wrong");
    AST_POP: assert property (take(5'h01) |=> pop_tail)
        else $error("pop load or completion wrong");
    AST_IO_SET: assert property (take(5'h02) |=> io_re_r ##1 io_we_r
        && io_wdata_r == ($past(io_rdata) | (8'h01 << $past(op_bit, 2))))
        else $error("io bit set data wrong");
    AST_IO_CLR: assert property (take(5'h03) |=> io_re_r ##1 io_we_r
        && io_wdata_r == ($past(io_rdata) & ~(8'h01 << $past(op_bit, 2))))
        else $error("io bit clear data wrong");
    AST_SHL: assert property (take(5'h04) |=> done_r && rf_we_r
        && rf_wdata_r == {rd_q[6:0], 1'b0})
        else $error("left shift wrong");
    AST_SHR: assert property (take(5'h05) |=>
        rf_wdata_r == {1'b0, rd_q[7:1]})
        else $error("right shift wrong");
    AST_ROL: assert property (take(5'h06) |=>
        rf_wdata_r == {rd_q[6:0], sr_q[0]}
        && status_register_r[0] == rd_q[7])
        else $error("rotate left wrong");
    AST_ROR: assert property (take(5'h07) |=>
        rf_wdata_r == {sr_q[0], rd_q[7:1]}
        && status_register_r[0] == rd_q[0])
        else $error("rotate right wrong");
    AST_ASR: assert property (take(5'h08) |=>
        rf_wdata_r == {rd_q[7], rd_q[7:1]})
        else $error("arithmetic shift wrong");
    AST_SWAP: assert property (take(5'h09) |=>
        rf_wdata_r == {rd_q[3:0], rd_q[7:4]}
        && status_register_r == sr_q)
        else $error("nibble swap wrong");
    AST_CARRY_ONE: assert property (take(5'h0e) |=>
        status_register_r == (sr_q | 8'h01))
        else $error("carry set touched other flags");
    AST_SP_PUSH: assert property (take(5'h00) |=> ##1
        sp_r == $past(sp_r, 2) - 16'h0001)
        else $error("stack pointer not stepped down");
endmodule

bind bfiu_unit bfiu_checker u_chk (
    .clk_sys(clk_sys), .srst(srst), .op_valid(op_valid),
    .op_code(op_code), .op_bit(op_bit), .rd_data(rd_data),
    .source_reg(source_reg), .busy_r(busy_r), .done_r(done_r),
    .rf_we_r(rf_we_r), .rf_wdata_r(rf_wdata_r), .stk_we_r(stk_we_r),
    .stk_re_r(stk_re_r), .stk_wdata_r(stk_wdata_r), .stk_rdata(stk_rdata),
    .io_re_r(io_re_r), .io_we_r(io_we_r), .io_wdata_r(io_wdata_r),
    .io_rdata(io_rdata), .status_register_r(status_register_r),
    .sp_r(sp_r)
);

// [test/bfiu_unit_tb.sv]
module bfiu_unit_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [4:0] c;
        logic [2:0] b;
        logic [7:0] d;
        logic [7:0] w;
        logic [7:0] s;
    } bfiu_row_t;
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic        op_valid = 1'b0;
    logic [4:0]  op_code = 5'h00;
    logic [2:0]  op_bit = 3'h0;
    logic [4:0]  rd_addr = 5'h00;
    logic [7:0]  rd_data = 8'h00;
    logic [7:0]  source_reg = 8'h00;
    logic [4:0]  io_addr = 5'h00;
    logic [7:0]  stk_rdata = 8'h00;
    logic [7:0]  io_rdata = 8'h00;
    wire         busy_r, done_r, illegal_r, rf_we_r, stk_we_r, stk_re_r;
    wire         io_re_r, io_we_r;
    wire  [4:0]  rf_waddr_r, io_addr_r;
    wire  [7:0]  rf_wdata_r, stk_wdata_r, io_wdata_r, status_register_r;
    wire  [15:0] stk_addr_r, sp_r;
    int          miscompares = 0;
    int          total_checks = 0;
    // rows run back to back, so each status column follows from the last
    bfiu_row_t   rows [27] = '{
        '{5'h0e,3'h0,8'h00,8'h00,8'h01}, '{5'h06,3'h0,8'h40,8'h81,8'h00},
        '{5'h07,3'h0,8'h01,8'h00,8'h01}, '{5'h07,3'h0,8'h02,8'h81,8'h00},
        '{5'h04,3'h0,8'h81,8'h02,8'h01}, '{5'h05,3'h0,8'h81,8'h40,8'h01},
        '{5'h08,3'h0,8'h82,8'hc1,8'h00}, '{5'h09,3'h0,8'h3c,8'hc3,8'h00},
        '{5'h0a,3'h5,8'h00,8'hc3,8'h20}, '{5'h1a,3'h0,8'h00,8'hc3,8'h60},
        '{5'h0d,3'h0,8'h00,8'h01,8'h60}, '{5'h0c,3'h0,8'h00,8'h01,8'h20},
        '{5'h0b,3'h5,8'h00,8'h01,8'h00}, '{5'h10,3'h0,8'h00,8'h01,8'h04},
        '{5'h12,3'h0,8'h00,8'h01,8'h06}, '{5'h18,3'h0,8'h00,8'h01,8'h0e},
        '{5'h16,3'h0,8'h00,8'h01,8'h1e}, '{5'h14,3'h0,8'h00,8'h01,8'h9e},
        '{5'h0e,3'h0,8'h00,8'h01,8'h9f}, '{5'h0f,3'h0,8'h00,8'h01,8'h9e},
        '{5'h11,3'h0,8'h00,8'h01,8'h9a}, '{5'h13,3'h0,8'h00,8'h01,8'h98},
        '{5'h19,3'h0,8'h00,8'h01,8'h90}, '{5'h17,3'h0,8'h00,8'h01,8'h80},
        '{5'h15,3'h0,8'h00,8'h01,8'h00}, '{5'h1a,3'h0,8'h00,8'h01,8'h40},
        '{5'h1b,3'h0,8'h00,8'h01,8'h00}};

    bfiu_unit DUT (
        .clk_sys(clk_sys), .srst(srst), .op_valid(op_valid),
        .op_code(op_code), .op_bit(op_bit), .rd_addr(rd_addr),
        .rd_data(rd_data), .source_reg(source_reg), .io_addr(io_addr),
        .busy_r(busy_r), .done_r(done_r), .illegal_r(illegal_r),
        .rf_we_r(rf_we_r), .rf_waddr_r(rf_waddr_r), .rf_wdata_r(rf_wdata_r),
        .stk_we_r(stk_we_r), .stk_re_r(stk_re_r), .stk_addr_r(stk_addr_r),
        .stk_wdata_r(stk_wdata_r), .stk_rdata(stk_rdata),
        .io_re_r(io_re_r), .io_we_r(io_we_r), .io_addr_r(io_addr_r),
        .io_wdata_r(io_wdata_r), .io_rdata(io_rdata),
        .status_register_r(status_register_r), .sp_r(sp_r)
    );

    always #50 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic issue(input logic [4:0] c, input logic [2:0] b);
        op_valid = 1'b1;
        op_code = c;
        op_bit = b;
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        tick(5);
        srst = 1'b0;
        chk("sp_rst", sp_r, 16'h00ff);
        for (int i = 0; i < 27; i++) begin
            issue(rows[i].c, rows[i].b);
            rd_data = rows[i].d;
            source_reg = rows[i].d;
            tick(1);
            chk("done", {15'h0000, done_r}, 16'h0001);
            chk("wdata", {8'h00, rf_wdata_r}, {8'h00, rows[i].w});
            chk("status", {8'h00, status_register_r}, {8'h00, rows[i].s});
        end
        // request stays up while busy: a second push must not be queued
        issue(5'h00, 3'h0);
        source_reg = 8'ha5;
        tick(1);
        chk("push", {6'h00, busy_r, stk_we_r, stk_wdata_r}, 16'h03a5);
        chk("push_addr", stk_addr_r, 16'h00ff);
        tick(1);
        op_valid = 1'b0;
        chk("push_done", {14'h0000, busy_r, done_r}, 16'h0001);
        tick(1);
        chk("push_sp", sp_r, 16'h00fe);
        chk("push_once", {15'h0000, stk_we_r}, 16'h0000);
        issue(5'h01, 3'h0);
        rd_addr = 5'h07;
        stk_rdata = 8'h5a;
        tick(1);
        op_valid = 1'b0;
        chk("pop_addr", {stk_re_r, stk_addr_r[14:0]}, 16'h80ff);
        tick(1);
        chk("pop", {1'b0, done_r, rf_we_r, rf_waddr_r, rf_wdata_r},
            16'h675a);
        for (int k = 0; k < 2; k++) begin
            issue(k ? 5'h03 : 5'h02, k ? 3'h7 : 3'h3);
            io_addr = 5'h11;
            io_rdata = 8'h81;
            tick(1);
            op_valid = 1'b0;
            chk("io_rd", {10'h000, io_re_r, io_addr_r}, 16'h0031);
            tick(1);
            chk("io_wr", {7'h00, io_we_r, io_wdata_r},
                k ? 16'h0101 : 16'h0189);
            tick(1);
            chk("io_done", {15'h0000, done_r}, 16'h0001);
        end
        // unknown code: completes at once, flagged, status untouched
        issue(5'h1c, 3'h0);
        tick(1);
        chk("illegal", {6'h00, done_r, illegal_r, status_register_r},
            16'h0300);
        issue(5'h0e, 3'h0);
        tick(1);
        op_valid = 1'b0;
        srst = 1'b1;
        tick(1);
        srst = 1'b0;
        chk("rst_again", {8'h00, status_register_r}, 16'h0000);
        tally_and_finish();
    end
    // run needs about 46 cycles; allow plenty
    initial begin
        #40000;
        miscompares++;
        tally_and_finish();
    end
endmodule
